// *** design/rxfs_pkg.sv ***
/*
 * constants for the receive frame-sync and fifo status block.
 * assumes 12-bit words from a sampler on the same clock.
 */
package rxfs_pkg;
    // ------------------------------------------------------------
    // spi opcodes and frame length
    // ------------------------------------------------------------
    localparam logic [7:0] OP_STATUS_RD = 8'he6;
    localparam logic [7:0] OP_CONTROL_REGISTER_ONE_RD  = 8'he2;
    localparam logic [7:0] OP_CONTROL_REGISTER_ONE_WR  = 8'h62;
    localparam logic [4:0] SPI_OP_LAST  = 5'h07;
    localparam logic [4:0] SPI_WR_LAST  = 5'h0f;
    // ------------------------------------------------------------
    // receive_fifo_status fields
    // ------------------------------------------------------------
    localparam int LOCK_BIT  = 7;
    localparam int PHASE_LSB = 5;
    localparam int FULL_BIT  = 4;
    localparam int HALF_BIT  = 3;
    localparam int EMPTY_BIT = 2;
    localparam int OVF_BIT   = 1;
    // ------------------------------------------------------------
    // control_register_one fields and reset
    // ------------------------------------------------------------
    localparam int CTRL_SOFT_RESET_BIT = 3;
    localparam int CTRL_TWO  = 2;
    localparam int CTRL_BYP  = 1;
    localparam logic [7:0] CONTROL_REGISTER_ONE_RESET = 8'h00;
    localparam logic [7:0] CONTROL_REGISTER_ONE_MASK  = 8'h0f;
    // ------------------------------------------------------------
    // word stream, fifo and marks
    // ------------------------------------------------------------
    localparam int WORD_W     = 12;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_HALF  = 16;
    localparam int SYNC_SPACING_S = 1; // marks one second apart
    localparam logic [2:0] HITS_FOUR = 3'h5;
    localparam logic [2:0] HITS_TWO  = 3'h3;

    typedef enum logic [1:0] {
        RXFS_HUNT   = 2'b00,
        RXFS_VERIFY = 2'b01,
        RXFS_LOCKED = 2'b10
    } rxfs_hunt_e;

    // sync mark word for a subframe phase
    function automatic logic [11:0] rxfs_mark(input logic [1:0] idx);
        case (idx)
            2'h0:    rxfs_mark = 12'h247;
            2'h1:    rxfs_mark = 12'h5b8;
            2'h2:    rxfs_mark = 12'ha47;
            default: rxfs_mark = 12'hdb8;
        endcase
    endfunction
endpackage

// *** design/rxfs_word_if.sv ***
/*
 * word stream carrier between the top and the sync hunter.
 * assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps
interface rxfs_word_if;
    logic        valid;     // word strobe
    logic [11:0] data;      // received word
    logic        pass;      // word may enter the fifo
    logic        lock;      // frame lock state
    logic        mark_seen; // passed word is a sync mark
    logic [1:0]  mark_idx;  // phase of that mark
    modport top    (output valid, data,
                    input  pass, lock, mark_seen, mark_idx);
    modport hunter (input  valid, data,
                    output pass, lock, mark_seen, mark_idx);
endinterface

// *** design/rxfs_fifo.sv ***
/*
 * receive word fifo with registered read port and fill count.
 * assumes writes are already refused by the caller when full.
 */
`timescale 1ns/1ps
module rxfs_fifo #(
    parameter int W     = 12,
    parameter int DEPTH = 32
) (
    input  wire logic                       clk_sys, // clock
    input  wire logic                       rst,     // sync reset
    input  wire logic                       clr,     // empty it
    input  wire logic                       wr,      // write strobe
    input  wire logic [W-1:0]               wr_data, // write word
    input  wire logic                       rd,      // read strobe
    output logic      [W-1:0]               rd_data, // read word
    output logic      [$clog2(DEPTH):0]     count    // fill level
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    wire do_rd = rd && (count != '0);
    wire do_wr = wr && (count != (AW+1)'(DEPTH));

    // storage: the array is only touched on a real write
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wp] <= wr_data;
        end
    end

    // pointers and count; clear leaves the array untouched
    always_ff @(posedge clk_sys) begin
        if (rst || clr) begin
            wp      <= '0;
            rp      <= '0;
            count   <= '0;
            rd_data <= '0;
        end else begin
            if (do_wr) wp <= wp + 1'b1;
            if (do_rd) begin
                rp      <= rp + 1'b1;
                rd_data <= mem[rp];
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

// *** design/rxfs_hunter.sv ***
/*
 * subframe sync mark hunter: verifies spacing and order, holds lock.
 * assumes words_per_sec is steady and at least two.
 */
`timescale 1ns/1ps
module rxfs_hunter (
    input  wire logic        clk_sys,       // clock
    input  wire logic        rst,           // sync reset
    input  wire logic        clr,           // restart search
    input  wire logic        two_mark,      // two-mark mode
    input  wire logic [13:0] words_per_sec, // mark spacing in words
    rxfs_word_if.hunter      w              // word stream
);
    rxfs_pkg::rxfs_hunt_e state;
    logic [13:0] cnt;
    logic [1:0]  expect_idx;
    logic [2:0]  hits;

    // mark decode of the current word
    wire [1:0] hit_idx = (w.data == rxfs_pkg::rxfs_mark(2'h1)) ? 2'h1 :
                         (w.data == rxfs_pkg::rxfs_mark(2'h2)) ? 2'h2 :
                         (w.data == rxfs_pkg::rxfs_mark(2'h3)) ? 2'h3 :
                         2'h0;
    wire any_mark = (w.data == rxfs_pkg::rxfs_mark(hit_idx));
    wire is_first = (w.data == rxfs_pkg::rxfs_mark(2'h0));
    wire start    = two_mark ? any_mark : is_first;  // R2 R3
    wire at_slot  = (cnt == words_per_sec - 14'h1);
    wire exp_hit  = (w.data == rxfs_pkg::rxfs_mark(expect_idx));
    wire [2:0] need = two_mark ? rxfs_pkg::HITS_TWO
                               : rxfs_pkg::HITS_FOUR;
    wire hunting  = (state == rxfs_pkg::RXFS_HUNT);
    wire good     = w.valid && !hunting && at_slot && exp_hit;
    // a wrong word at a mark slot ends lock and that word is not stored
    wire lost     = w.valid && !hunting && at_slot && !exp_hit;
    wire locking  = good && (state == rxfs_pkg::RXFS_VERIFY)
                         && (hits + 3'h1 == need);

    // stream answers: only locked words or the locking mark pass
    assign w.lock      = (state == rxfs_pkg::RXFS_LOCKED);       // R1
    assign w.pass      = w.valid && ((w.lock && !lost) || locking); // R5
    assign w.mark_seen = good && (w.lock || locking);             // R7
    assign w.mark_idx  = expect_idx;                              // R9

    // search, verify and lock; a wrong word at a mark slot drops to hunt, marks off the slot are not checked
    always_ff @(posedge clk_sys) begin
        if (rst || clr) begin
            state      <= rxfs_pkg::RXFS_HUNT;                    // R18
            cnt        <= '0;
            expect_idx <= '0;
            hits       <= '0;
        end else if (w.valid) begin
            if (hunting) begin
                if (start) begin
                    state      <= rxfs_pkg::RXFS_VERIFY;
                    expect_idx <= hit_idx + 2'h1;
                    hits       <= 3'h1;
                    cnt        <= '0;
                end
            end else if (!at_slot) begin
                cnt <= cnt + 14'h1;
            end else if (exp_hit) begin
                expect_idx <= expect_idx + 2'h1;
                cnt        <= '0;
                if (hits != need) hits <= hits + 3'h1;
                if (locking) state <= rxfs_pkg::RXFS_LOCKED;      // R2 R3
            end else begin
                state <= rxfs_pkg::RXFS_HUNT;                     // R4
                hits  <= '0;
            end
        end
    end
endmodule

// *** design/rxfs_frame_sync.sv ***
/*
 * receive frame sync and fifo status block with its spi register port.
 * assumes a 12-bit word sampler and the word-rate setting on clk_sys,
 * and an spi host in mode 0 with sclk well below clk_sys / 4.
 */
// Summary of operation
// [R1] lock flag bit 7 and pin once synced
// [R2] four marks in order, lock on next 1107
// [R3] two-mark mode: any two ordered marks
// [R4] lock holds until lost, then re-hunt
// [R5] no fifo writes without sync
// [R6] stored words survive loss of sync
// [R7] phase bits 6-5 update on passed mark; here only when that mark is also stored, so not while the fifo is full
// [R8] host trusts phase only four-mark locked
// [R9] phase codes 00,01,10,11 per mark
// [R10] full flag bit 4 at 32 words
// [R11] half flag bit 3 exactly 16 words
// [R12] empty flag bit 2, set from reset
// [R13] overflow bit and pin on full write
// [R14] words dropped while fifo full
// [R15] bit 0 always reads zero
// [R16] status read by opcode e6, no write
// [R17] bypass mode loads every word
// [R18] soft reset empties fifo, clears sync
// [R19] overflow sticky until soft reset
`timescale 1ns/1ps
module rxfs_frame_sync #(
    parameter int DEPTH = rxfs_pkg::FIFO_DEPTH
) (
    input  wire logic        clk_sys,         // 10 MHz clock
    input  wire logic        rst,             // sync reset, high
    input  wire logic        word_valid,      // sampler word strobe
    input  wire logic [11:0] word_data,       // sampler word
    input  wire logic [13:0] words_per_sec,   // word rate setting
    input  wire logic        fifo_rd,         // pop one fifo word
    output logic      [11:0] fifo_rd_data,    // popped word
    input  wire logic        spi_sclk,        // spi clock pin
    input  wire logic        spi_cs_n,        // spi select, low
    input  wire logic        spi_mosi,        // spi data in
    output logic             spi_miso,        // spi data out
    output logic             frame_lock_flag, // lock pin
    output logic             rx_overflow_pin  // overflow pin
);
    localparam int CW = $clog2(DEPTH) + 1;

    // ------------------------------------------------------------
    // control_register_one and flags
    // ------------------------------------------------------------
    logic [7:0] control_register_one;
    logic       rx_fifo_overflow_flag;
    logic [1:0] subframe_phase;
    logic       next_overflow;
    logic [CW-1:0] fill;

    wire soft_reset_bit     = control_register_one[rxfs_pkg::CTRL_SOFT_RESET_BIT];
    wire two_mark_sync_mode = control_register_one[rxfs_pkg::CTRL_TWO];
    wire sync_bypass_mode   = control_register_one[rxfs_pkg::CTRL_BYP];

    // ------------------------------------------------------------
    // sync hunter
    // ------------------------------------------------------------
    rxfs_word_if w ();
    assign w.valid = word_valid;
    assign w.data  = word_data;

    // bypass holds the hunter idle so lock stays low in that mode
    rxfs_hunter u_hunter (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .clr           (soft_reset_bit || sync_bypass_mode), // R17 R18
        .two_mark      (two_mark_sync_mode),
        .words_per_sec (words_per_sec),
        .w             (w)
    );

    // ------------------------------------------------------------
    // fifo write path
    // ------------------------------------------------------------
    wire fifo_full  = (fill == CW'(DEPTH));                      // R10
    wire fifo_half  = (fill == CW'(rxfs_pkg::FIFO_HALF));        // R11
    wire fifo_empty = (fill == '0);                              // R12
    wire wr_try     = !soft_reset_bit &&
                      (sync_bypass_mode ? word_valid : w.pass);   // R5 R17
    wire wr_go      = wr_try && !fifo_full;                      // R14
    wire ovf_set    = wr_try && fifo_full;                       // R13

    // loss of lock never clears the fifo, only soft reset does
    rxfs_fifo #(
        .W     (rxfs_pkg::WORD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clr     (soft_reset_bit),                               // R6 R18
        .wr      (wr_go),
        .wr_data (word_data),
        .rd      (fifo_rd),
        .rd_data (fifo_rd_data),
        .count   (fill)
    );

    // overflow: set beats clear, cleared only by soft reset
    assign next_overflow = ovf_set ||
        (rx_fifo_overflow_flag && !soft_reset_bit);             // R19

    // flags and pins; overflow pin mirrors its status bit, lock pin follows bit 7 one cycle later
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_fifo_overflow_flag <= 1'b0;
            rx_overflow_pin       <= 1'b0;
            frame_lock_flag       <= 1'b0;
        end else begin
            rx_fifo_overflow_flag <= next_overflow;              // R13
            rx_overflow_pin       <= next_overflow;              // R13
            frame_lock_flag       <= w.lock;                     // R1
        end
    end

    // phase follows each mark matched at its slot that enters the fifo, never in bypass
    always_ff @(posedge clk_sys) begin
        if (rst || soft_reset_bit) begin
            subframe_phase <= 2'h0;
        end else if (w.mark_seen && wr_go && !sync_bypass_mode) begin
            subframe_phase <= w.mark_idx;                        // R7 R9
        end
    end

    // ------------------------------------------------------------
    // receive_fifo_status assembly
    // ------------------------------------------------------------
    wire [7:0] receive_fifo_status = {
        w.lock,                                                  // R1
        subframe_phase,                                          // R7
        fifo_full,
        fifo_half,
        fifo_empty,
        rx_fifo_overflow_flag,
        1'b0                                                     // R15
    };

    // ------------------------------------------------------------
    // spi slave, mode 0, pins synchronised
    // ------------------------------------------------------------
    logic [2:0] sclk_q;
    logic [1:0] cs_q;
    logic [1:0] mosi_q;
    logic [4:0] bit_cnt;
    logic [7:0] in_sh;
    logic [7:0] tx_sh;
    logic [7:0] opcode;

    // first stage feeds the second only; third stage is for edges
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sclk_q <= 3'h0;
            cs_q   <= 2'h3;
            mosi_q <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], spi_sclk};
            cs_q   <= {cs_q[0], spi_cs_n};
            mosi_q <= {mosi_q[0], spi_mosi};
        end
    end

    wire sel      = !cs_q[1];
    wire rise     = sel && sclk_q[1] && !sclk_q[2];
    wire fall     = sel && !sclk_q[1] && sclk_q[2];
    wire [7:0] in_byte = {in_sh[6:0], mosi_q[1]};
    wire op_done  = rise && (bit_cnt == rxfs_pkg::SPI_OP_LAST);
    wire wr_done  = rise && (bit_cnt == rxfs_pkg::SPI_WR_LAST) &&
                    (opcode == rxfs_pkg::OP_CONTROL_REGISTER_ONE_WR);
    wire data_ph  = bit_cnt[4] || (bit_cnt[3] && bit_cnt != 5'h08) ||
                    (bit_cnt == 5'h08);

    // read value chosen by opcode; status has no write opcode
    wire [7:0] rd_value =
        (in_byte == rxfs_pkg::OP_STATUS_RD) ? receive_fifo_status :  // R16
        (in_byte == rxfs_pkg::OP_CONTROL_REGISTER_ONE_RD)  ? control_register_one :
        8'h00;

    // bit counter, opcode capture and shift registers
    always_ff @(posedge clk_sys) begin
        if (rst || !sel) begin
            bit_cnt <= 5'h00;
            in_sh   <= 8'h00;
            tx_sh   <= 8'h00;
            opcode  <= 8'h00;
        end else begin
            if (rise) begin
                in_sh <= in_byte;
                if (bit_cnt != 5'h1f) bit_cnt <= bit_cnt + 5'h01;
            end
            if (op_done) begin
                opcode <= in_byte;
                tx_sh  <= rd_value;                              // R16
            end else if (fall && data_ph) begin
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
        end
    end

    // miso changes on the falling edge, msb first
    always_ff @(posedge clk_sys) begin
        if (rst || !sel) begin
            spi_miso <= 1'b0;
        end else if (fall && data_ph) begin
            spi_miso <= tx_sh[7];
        end
    end

    // control write lands on the sixteenth rising edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            control_register_one <= rxfs_pkg::CONTROL_REGISTER_ONE_RESET;
        end else if (wr_done) begin
            control_register_one <= in_byte & rxfs_pkg::CONTROL_REGISTER_ONE_MASK;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_lock_pin_follow: assert property ( // R1
        @(posedge clk_sys) disable iff (rst)
        $rose(w.lock) |=> frame_lock_flag && receive_fifo_status[7])
        else $error("lock pin did not follow lock");

    a_no_unsync_wr: assert property ( // R5
        @(posedge clk_sys) disable iff (rst)
        wr_go && !sync_bypass_mode |-> w.lock || w.mark_seen)
        else $error("fifo written without sync");

    a_lock_drop_keep: assert property ( // R6
        @(posedge clk_sys) disable iff (rst)
        $fell(w.lock) && !$past(soft_reset_bit) &&
        !$past(sync_bypass_mode) && !$past(fifo_rd)
        |-> fill == $past(fill))
        else $error("fifo changed on loss of lock");

    a_lock_loss: assert property ( // R4
        @(posedge clk_sys) disable iff (rst)
        w.lock && w.valid && !w.pass |=> !w.lock)
        else $error("lock held after a missed mark");

    a_phase_update: assert property ( // R7
        @(posedge clk_sys) disable iff (rst)
        w.mark_seen && wr_go && !sync_bypass_mode
        |=> subframe_phase == $past(w.mark_idx))
        else $error("phase not updated on mark");

    a_phase_hold: assert property ( // R7
        @(posedge clk_sys) disable iff (rst)
        w.mark_seen && !wr_go && !soft_reset_bit |=> $stable(subframe_phase))
        else $error("phase moved on a mark not stored");

    a_full_flag: assert property ( // R10
        @(posedge clk_sys) disable iff (rst)
        receive_fifo_status[4] == (fill == CW'(32)))
        else $error("full flag wrong");

    a_half_exact: assert property ( // R11
        @(posedge clk_sys) disable iff (rst)
        receive_fifo_status[3] |-> fill == CW'(16))
        else $error("half flag set off sixteen words");

    a_empty_flag: assert property ( // R12
        @(posedge clk_sys) disable iff (rst)
        fifo_empty && wr_go && !fifo_rd |=> !receive_fifo_status[2])
        else $error("empty flag not cleared by first word");

    a_ovf_set_pin: assert property ( // R13
        @(posedge clk_sys) disable iff (rst)
        wr_try && fifo_full |=> rx_fifo_overflow_flag && rx_overflow_pin)
        else $error("overflow not flagged");

    a_full_drop: assert property ( // R14
        @(posedge clk_sys) disable iff (rst)
        fifo_full && wr_try && !fifo_rd |=> fill == CW'(DEPTH))
        else $error("word stored into full fifo");

    a_bit0_zero: assert property ( // R15
        @(posedge clk_sys) disable iff (rst)
        op_done && in_byte == rxfs_pkg::OP_STATUS_RD |=> !tx_sh[0])
        else $error("status bit 0 not zero");

    a_bypass_load: assert property ( // R17
        @(posedge clk_sys) disable iff (rst)
        sync_bypass_mode && !soft_reset_bit && word_valid && !fifo_full
        |-> wr_go)
        else $error("bypass word not loaded");

    a_soft_reset_bit_clear: assert property ( // R18
        @(posedge clk_sys) disable iff (rst)
        soft_reset_bit ##1 soft_reset_bit |-> fill == '0 && !w.lock)
        else $error("soft reset left fifo or lock");

    a_ovf_sticky: assert property ( // R19
        @(posedge clk_sys) disable iff (rst)
        rx_fifo_overflow_flag && !soft_reset_bit
        |=> rx_fifo_overflow_flag [*2] or soft_reset_bit)
        else $error("overflow flag dropped");
endmodule

// *** design/rxfs_frame_sync_end.sv ***
/*
 * holds no logic; the block's top level is rxfs_frame_sync.
 * assumes nothing of its surroundings.
 */

// *** bench/rxfs_word_src.sv ***
/* word sampler stand-in for the receive side.
   assumes the bench drives send and d just after clk_sys rises. */
`timescale 1ns/1ps
module rxfs_word_src (
    input  wire logic        clk_sys,    // clock
    input  wire logic        send,       // word request
    input  wire logic [11:0] d,          // word to send
    output logic             word_valid, // word strobe
    output logic      [11:0] word_data   // word bus
);
    initial begin
        word_valid = 1'b0;
        word_data  = 12'h000;
    end
    // idle cycles show the inverse so stale data never passes for valid
    always @(posedge clk_sys) begin
        word_valid <= send;
        word_data  <= send ? d : ~word_data;
    end
endmodule

// *** bench/test_rxfs_frame_sync.sv ***
/* self-checking bench: spi host tasks, word source, queue model.
   assumes a mark spacing of four words on words_per_sec. */
`timescale 1ns/1ps
module test_rxfs_frame_sync;
    localparam int W = 4;
    localparam int H = 6;
    localparam int DEPTH = 32;
    logic        clk_sys, rst, send, fifo_rd, sclk, cs_n, mosi;
    logic [11:0] src_d, word_data, rd_data;
    logic        word_valid, miso, lock_pin, ovf_pin;
    logic        m_lock, m_ovf, m_two, m_byp;
    logic [1:0]  m_ph;
    logic [11:0] q[$];
    logic [11:0] marks[4];
    logic [7:0]  rx;
    int          mismatches, compares, seed, hits, nxt, gap, s_pos, s_idx;

    rxfs_word_src src (.clk_sys(clk_sys), .send(send), .d(src_d),
        .word_valid(word_valid), .word_data(word_data));
    rxfs_frame_sync dut (.clk_sys(clk_sys), .rst(rst),
        .word_valid(word_valid), .word_data(word_data),
        .words_per_sec(14'(W)), .fifo_rd(fifo_rd), .fifo_rd_data(rd_data),
        .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
        .frame_lock_flag(lock_pin), .rx_overflow_pin(ovf_pin));

    // 10 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // a hang costs a mismatch and ends the run
    initial begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // model and drivers
    // ------------------------------------------------------------
    task automatic check(string nm, logic [11:0] seen, logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // mode 0, msb first; slow sclk so the synchronisers keep up
    task automatic spi(input logic [15:0] tx);
        @(posedge clk_sys) cs_n <= 1'b0;
        repeat (H) @(posedge clk_sys);
        for (int i = 15; i >= 0; i--) begin
            mosi <= tx[i];
            repeat (H) @(posedge clk_sys);
            sclk <= 1'b1;
            if (i < 8) rx[i] = miso;
            repeat (H) @(posedge clk_sys);
            sclk <= 1'b0;
        end
        repeat (H) @(posedge clk_sys);
        cs_n <= 1'b1;
        repeat (H) @(posedge clk_sys);
    endtask
    task automatic clr_model();
        q.delete();
        hits   = 0;
        m_lock = 1'b0;
        m_ovf  = 1'b0;
        m_ph   = 2'b00;
    endtask
    task automatic ctrl(input logic [7:0] v);
        spi({8'h62, v});
        m_two = v[2];
        m_byp = v[1];
        if (v[3]) clr_model();
    endtask
    task automatic status(input logic ph_ok);
        logic [7:0] e;
        spi({8'he6, 8'h00});
        e = {m_lock, m_ph, q.size() == DEPTH, q.size() == 16,
             q.size() == 0, m_ovf, 1'b0};
        if (!ph_ok) begin
            rx[6:5] = 2'b00;
            e[6:5]  = 2'b00;
        end
        check("receive_fifo_status", {4'h0, rx}, {4'h0, e});
        check("frame_lock_flag", {11'h0, lock_pin}, {11'h0, m_lock});
        check("rx_overflow_pin", {11'h0, ovf_pin}, {11'h0, m_ovf});
        $display("test step done");
    endtask
    // one word to the source, model updated alongside
    task automatic feed(input logic [11:0] d);
        int mi;
        mi = -1;
        for (int k = 0; k < 4; k++) if (d === marks[k]) mi = k;
        @(posedge clk_sys);
        send  <= 1'b1;
        src_d <= d;
        if (m_byp) m_lock = 1'b0;
        else begin
            if (hits > 0) gap++;
            if (hits == 0) begin
                if (mi == 0 || (m_two && mi >= 0)) begin
                    hits = 1;
                    nxt  = (mi + 1) % 4;
                    gap  = 0;
                end
            end else if (gap == W) begin
                if (mi == nxt) begin
                    hits++;
                    nxt = (nxt + 1) % 4;
                    gap = 0;
                end else hits = 0;
            end
            m_lock = hits >= (m_two ? 3 : 5);
        end
        if (m_byp || m_lock) begin
            if (q.size() == DEPTH) m_ovf = 1'b1;
            else begin
                q.push_back(d);
                if (mi >= 0 && !m_byp) m_ph = 2'(mi);
            end
        end
    endtask
    task automatic fill1();
        logic [11:0] d;
        d = 12'($random(seed));
        for (int k = 0; k < 4; k++) if (d === marks[k]) d ^= 12'h001;
        feed(d);
    endtask
    task automatic stream(input int n);
        for (int i = 0; i < n; i++) begin
            if (s_pos % W == 0) begin
                feed(marks[s_idx]);
                s_idx = (s_idx + 1) % 4;
            end else fill1();
            s_pos++;
        end
        @(posedge clk_sys) send <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic pop(input int n);
        repeat (n) begin
            @(posedge clk_sys) fifo_rd <= 1'b1;
            @(posedge clk_sys) fifo_rd <= 1'b0;
            #1 check("fifo_rd_data", rd_data, q.pop_front());
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {send, fifo_rd, sclk, mosi, m_two, m_byp} = '0;
        cs_n  = 1'b1;
        src_d = 12'h000;
        seed  = 57800;
        mismatches = 0;
        compares   = 0;
        marks = '{12'h247, 12'h5b8, 12'ha47, 12'hdb8};
        clr_model();
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        status(1'b1);
        spi({8'hd5, 8'h00});
        check("unknown opcode", {4'h0, rx}, 12'h000);
        s_pos = 0;
        s_idx = 0;
        stream(4 * W + 1);
        status(1'b1);
        for (int k = 0; k < 3; k++) begin
            stream(W);
            status(1'b1);
        end
        stream(3);
        status(1'b1);
        stream(16);
        status(1'b1);
        stream(2);
        status(1'b1);
        pop(4);
        status(1'b1);
        for (int i = 0; i < 3 * W; i++) fill1();
        stream(0);
        status(1'b1);
        pop(q.size());
        s_pos = 0;
        s_idx = 0;
        stream(4 * W + 1);
        status(1'b1);
        ctrl(8'h08);
        status(1'b1);
        ctrl(8'h04);
        spi({8'he2, 8'h00});
        check("control_register_one", {4'h0, rx}, 12'h004);
        s_pos = 0;
        s_idx = 2;
        stream(2 * W + 1);
        status(1'b0);
        ctrl(8'h08);
        ctrl(8'h02);
        for (int i = 0; i < 5; i++) fill1();
        stream(0);
        status(1'b1);
        pop(5);
        report_and_stop();
    end
endmodule
